/* File: hdl/vtp_pkg.sv */
package vtp_pkg;
   // ------------------------------------------------------------
   // Modes, profile shapes and control/status/polarity/submode bit positions
   // ------------------------------------------------------------
   localparam logic [7:0] MODE_VEL      = 8'h02;
   localparam logic [7:0] MODE_PROF_VEL = 8'h03;
   localparam logic [7:0] MODE_PROF_TRQ = 8'h04;
   localparam logic [7:0] PROF_TRAP     = 8'h00;
   localparam logic [7:0] PROF_JERK     = 8'h03;
   localparam int         CTRL_HALT_BIT = 8;
   localparam int         STAT_TGT_BIT  = 10;
   localparam int         STAT_LIM_BIT  = 11;
   localparam int         POL_VEL_BIT   = 6;
   localparam int         SUBMODE_BIT   = 5;
   // ------------------------------------------------------------
   // Timing and torque scale
   // ------------------------------------------------------------
   localparam int         CLK_HZ        = 200_000_000;
   localparam int         PERIOD_US     = 1000;
   localparam int         PERIOD_CYC    = CLK_HZ / 1_000_000 * PERIOD_US;
   localparam int         TICKS_PER_S   = 1_000_000 / PERIOD_US;
   localparam int         TRQ_FULL      = 1000;
   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [15:0] STATUS_RST   = 16'h0000;
   localparam logic [31:0] DEMAND_RST   = 32'h0000_0000;
endpackage

/* File: hdl/vtp_window.sv */
module vtp_window #(
   parameter int W = 32
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         tick,
   input  wire logic         clr,
   input  wire logic [W-1:0] actual,
   input  wire logic [W-1:0] target,
   input  wire logic [W-1:0] window,
   input  wire logic [15:0]  time_ms,
   output logic              reached_r
);
   logic [W-1:0] diff;
   logic [15:0]  cnt_r;

   always_comb begin
      if ($signed(actual) > $signed(target)) begin
         diff = actual - target;
      end else begin
         diff = target - actual;
      end
   end

   // Dwell counter restarts whenever the value leaves the window.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r     <= 16'h0000;
         reached_r <= 1'b0;
      end else if (clr) begin
         cnt_r     <= 16'h0000;
         reached_r <= 1'b0;
      end else if (tick) begin
         if (diff > window) begin
            cnt_r     <= 16'h0000;
            reached_r <= 1'b0;
         end else if (cnt_r >= time_ms) begin
            reached_r <= 1'b1;
         end else begin
            cnt_r <= cnt_r + 16'h0001;
         end
      end
   end
endmodule

/* File: hdl/vtp_top.sv */
// How it works
// - Velocity ramp tracks target within limits.
// - Status bit 11 while limit constrains ramp.
// - Halt bit 8 brakes; release restarts ramp.
// - Bits 10/8 report velocity progress states.
// - Bit 10 after speed dwell in window.
// - Polarity bit 6 inverts commanded speed.
// - Profile type 0 trapezoid, 3 jerk-limited.
// - Accel, decel and quick-stop rates used.
// - Runs only when operation enabled.
// - Ramp output is demand and setpoint.
// - Torque mode needs closed loop active.
// - Halt ramps torque down, release restarts.
// - Bits 8/10 report torque progress states.
// - Torque reached after window dwell time.
// - Bit 11 when target torque exceeds max.
// - Torque values in thousandths of rated.
// - Torque limited and slope per second.
// - Clamp to peak; above rated needs duration.
// - Submode bit 5 clear enables speed cap.
module vtp_top #(
   parameter int PERIOD = vtp_pkg::PERIOD_CYC
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [7:0]  mode,
   input  wire logic [15:0] control,
   input  wire logic        op_enabled,
   input  wire logic        quick_stop,
   input  wire logic        closed_loop,
   input  wire logic [7:0]  polarity,
   input  wire logic [7:0]  profile_type,
   input  wire logic [31:0] target_vel,
   input  wire logic [31:0] vel_min,
   input  wire logic [31:0] vel_max,
   input  wire logic [31:0] prof_acc,
   input  wire logic [31:0] prof_dec,
   input  wire logic [31:0] qs_dec,
   input  wire logic [31:0] max_acc,
   input  wire logic [31:0] max_dec,
   input  wire logic [31:0] jerk,
   input  wire logic [31:0] actual_vel,
   input  wire logic [31:0] vel_window,
   input  wire logic [15:0] vel_window_ms,
   input  wire logic [15:0] target_trq,
   input  wire logic [15:0] max_trq,
   input  wire logic [15:0] trq_slope,
   input  wire logic [15:0] peak_trq,
   input  wire logic [15:0] peak_dur,
   input  wire logic [15:0] actual_trq,
   input  wire logic [15:0] trq_window,
   input  wire logic [15:0] trq_window_ms,
   input  wire logic [7:0]  motor_submode,
   input  wire logic [31:0] speed_cap,
   output logic [15:0]      status_r,
   output logic [31:0]      vel_demand_r,
   output logic [31:0]      vel_setpoint_r,
   output logic [15:0]      trq_demand_r,
   output logic             speed_cap_en_r,
   output logic             field_weak_en_r
);
   // ------------------------------------------------------------
   // Reset release and control period
   // ------------------------------------------------------------
   logic        rst_m_r;
   logic        rst_n;
   logic [31:0] div_r;
   logic        tick;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_m_r <= 1'b0;
         rst_n   <= 1'b0;
      end else begin
         rst_m_r <= 1'b1;
         rst_n   <= rst_m_r;
      end
   end

   // One enable pulse per control period.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_r <= 32'h0000_0000;
      end else if (div_r >= 32'(PERIOD - 1)) begin
         div_r <= 32'h0000_0000;
      end else begin
         div_r <= div_r + 32'h0000_0001;
      end
   end
   assign tick = (div_r == 32'(PERIOD - 1));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] smin(input logic [31:0] a, input logic [31:0] b);
      smin = ($signed(a) < $signed(b)) ? a : b;
   endfunction

   function automatic logic [31:0] smax(input logic [31:0] a, input logic [31:0] b);
      smax = ($signed(a) > $signed(b)) ? a : b;
   endfunction

   function automatic logic [31:0] umin(input logic [31:0] a, input logic [31:0] b);
      umin = (a < b) ? a : b;
   endfunction

   // ------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------
   logic halt;
   logic vel_mode;
   logic pv_mode;
   logic pt_mode;
   logic halt_d_r;
   logic vel_run;
   logic trq_run;

   assign halt     = control[vtp_pkg::CTRL_HALT_BIT];
   assign pv_mode  = (mode == vtp_pkg::MODE_PROF_VEL);
   assign vel_mode = pv_mode || (mode == vtp_pkg::MODE_VEL);
   assign pt_mode  = (mode == vtp_pkg::MODE_PROF_TRQ);
   assign vel_run  = vel_mode && op_enabled;
   assign trq_run  = pt_mode && op_enabled && closed_loop;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         halt_d_r <= 1'b0;
      end else if (tick) begin
         halt_d_r <= halt;
      end
   end

   // ------------------------------------------------------------
   // Velocity ramp generator
   // ------------------------------------------------------------
   logic [31:0] cmd_vel;
   logic [31:0] goal_vel;
   logic [31:0] acc_lim;
   logic [31:0] dec_lim;
   logic [31:0] step_lim;
   logic [31:0] acc_r;
   logic [31:0] acc_want;
   logic [31:0] dv;
   logic [31:0] vel_nxt;
   logic        speeding_up;
   logic        vel_clamped;
   logic        rate_clamped;

   always_comb begin
      cmd_vel = polarity[vtp_pkg::POL_VEL_BIT] ? (32'h0 - target_vel) : target_vel;
      goal_vel = smin(smax(cmd_vel, vel_min), vel_max);
      vel_clamped = (goal_vel != cmd_vel);
      if (!vel_run || halt || quick_stop) begin
         goal_vel = 32'h0;
      end
      // Leaving zero in either direction is speeding up, so it takes the acceleration rate.
      speeding_up = ($signed(goal_vel) > $signed(vel_demand_r)) ? ($signed(vel_demand_r) >= 0)
                                                                : ($signed(vel_demand_r) <= 0);
      acc_lim = umin(prof_acc, max_acc);
      dec_lim = quick_stop ? qs_dec : umin(prof_dec, max_dec);
      step_lim = speeding_up ? acc_lim : dec_lim;
      rate_clamped = (prof_acc > max_acc) || (!quick_stop && prof_dec > max_dec);
      // Jerk-limited shape walks the step size toward its limit instead of jumping.
      if (pv_mode && profile_type == vtp_pkg::PROF_JERK) begin
         acc_want = umin(acc_r + jerk, step_lim);
      end else begin
         acc_want = step_lim;
      end
      dv = ($signed(goal_vel) > $signed(vel_demand_r)) ? goal_vel - vel_demand_r
                                                       : vel_demand_r - goal_vel;
      if (dv <= acc_want) begin
         vel_nxt = goal_vel;
      end else if ($signed(goal_vel) > $signed(vel_demand_r)) begin
         vel_nxt = vel_demand_r + acc_want;
      end else begin
         vel_nxt = vel_demand_r - acc_want;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         vel_demand_r   <= vtp_pkg::DEMAND_RST;
         vel_setpoint_r <= vtp_pkg::DEMAND_RST;
         acc_r          <= 32'h0;
      end else if (tick) begin
         vel_demand_r   <= vel_nxt;
         vel_setpoint_r <= vel_nxt;
         acc_r          <= (vel_nxt == goal_vel) ? 32'h0 : acc_want;
      end
   end

   // ------------------------------------------------------------
   // Torque ramp generator
   // ------------------------------------------------------------
   logic [15:0] trq_cap;
   logic [15:0] goal_trq;
   logic [15:0] slope_step;
   logic [15:0] trq_nxt;
   logic [15:0] dt;

   always_comb begin
      // Above-rated torque is only allowed when a peak duration exists.
      trq_cap = (peak_dur != 16'h0) ? peak_trq : 16'(vtp_pkg::TRQ_FULL);
      if (peak_trq < trq_cap) begin
         trq_cap = peak_trq;
      end
      if (max_trq < trq_cap) begin
         trq_cap = max_trq;
      end
      goal_trq = ($signed(target_trq) > $signed(trq_cap)) ? trq_cap : target_trq;
      if ($signed(goal_trq) < -$signed(trq_cap)) begin
         goal_trq = 16'h0 - trq_cap;
      end
      if (!trq_run || halt) begin
         goal_trq = 16'h0;
      end
      slope_step = 16'(trq_slope / 16'(vtp_pkg::TICKS_PER_S));
      if (slope_step == 16'h0) begin
         slope_step = 16'h0001;
      end
      dt = ($signed(goal_trq) > $signed(trq_demand_r)) ? goal_trq - trq_demand_r
                                                       : trq_demand_r - goal_trq;
      if (dt <= slope_step) begin
         trq_nxt = goal_trq;
      end else if ($signed(goal_trq) > $signed(trq_demand_r)) begin
         trq_nxt = trq_demand_r + slope_step;
      end else begin
         trq_nxt = trq_demand_r - slope_step;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         trq_demand_r    <= 16'h0;
         speed_cap_en_r  <= 1'b0;
         field_weak_en_r <= 1'b0;
      end else if (tick) begin
         trq_demand_r    <= trq_nxt;
         speed_cap_en_r  <= trq_run && !motor_submode[vtp_pkg::SUBMODE_BIT];
         field_weak_en_r <= trq_run && !motor_submode[vtp_pkg::SUBMODE_BIT];
      end
   end

   // ------------------------------------------------------------
   // Target windows
   // ------------------------------------------------------------
   logic vel_in_win;
   logic trq_in_win;

   vtp_window #(.W(32)) u_vel_win (
      .clk       (clk),
      .rst_n     (rst_n),
      .tick      (tick),
      .clr       (halt != halt_d_r),
      .actual    (actual_vel),
      .target    (goal_vel),
      .window    (vel_window),
      .time_ms   (vel_window_ms),
      .reached_r (vel_in_win)
   );

   vtp_window #(.W(16)) u_trq_win (
      .clk       (clk),
      .rst_n     (rst_n),
      .tick      (tick),
      .clr       (halt != halt_d_r),
      .actual    (actual_trq),
      .target    (goal_trq),
      .window    (trq_window),
      .time_ms   (trq_window_ms),
      .reached_r (trq_in_win)
   );

   // ------------------------------------------------------------
   // Status word
   // ------------------------------------------------------------
   logic tgt_bit;
   logic lim_bit;

   always_comb begin
      tgt_bit = 1'b0;
      lim_bit = 1'b0;
      if (vel_mode) begin
         // With halt set the window tracks zero, so bit 10 means stopped.
         tgt_bit = vel_in_win;
         lim_bit = vel_clamped || (rate_clamped && vel_nxt != goal_vel);
      end else if (pt_mode) begin
         tgt_bit = trq_in_win;
         lim_bit = $signed(target_trq) > $signed(max_trq);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_r <= vtp_pkg::STATUS_RST;
      end else if (tick) begin
         status_r <= vtp_pkg::STATUS_RST;
         status_r[vtp_pkg::STAT_TGT_BIT] <= tgt_bit;
         status_r[vtp_pkg::STAT_LIM_BIT] <= lim_bit;
      end
   end
endmodule

/* File: dv/vtp_master.sv */
module vtp_master (
   input  wire logic        clk,
   output logic [7:0]       mode,
   output logic [15:0]      control,
   output logic             op_enabled
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Mode and halt objects written by the master
   // ------------------------------------------------------------
   initial begin
      mode = 8'h00;
      control = 16'h0000;
      op_enabled = 1'b0;
   end
   task automatic select(input logic [7:0] m);
      @(posedge clk);
      mode <= m;
      op_enabled <= 1'b1;
   endtask
   task automatic halt(input logic h);
      @(posedge clk);
      control <= {7'h00, h, 8'h00};
   endtask
endmodule

/* File: dv/vtp_monitor.sv */
module vtp_monitor #(
   parameter int PERIOD = 8
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        op_enabled,
   input  wire logic        quick_stop,
   input  wire logic        closed_loop,
   input  wire logic [7:0]  mode,
   input  wire logic [7:0]  profile_type,
   input  wire logic [7:0]  motor_submode,
   input  wire logic [15:0] target_trq,
   input  wire logic [15:0] max_trq,
   input  wire logic [15:0] trq_slope,
   input  wire logic [15:0] status_r,
   input  wire logic [15:0] trq_demand_r,
   input  wire logic [31:0] prof_acc,
   input  wire logic [31:0] prof_dec,
   input  wire logic [31:0] vel_demand_r,
   input  wire logic [31:0] vel_setpoint_r,
   input  wire logic        speed_cap_en_r,
   input  wire logic        field_weak_en_r
);
   // ------------------------------------------------------------
   // Output relations
   // ------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   int vstep;
   int tstep;
   function automatic int mag(input int v);
      return (v < 0) ? -v : v;
   endfunction
   assign vstep = int'((prof_acc > prof_dec) ? prof_acc : prof_dec);
   // Slopes under one unit per tick still move by one, or the ramp would stall.
   assign tstep = (trq_slope < 16'(vtp_pkg::TICKS_PER_S)) ? 1
                                                           : int'(trq_slope) / vtp_pkg::TICKS_PER_S;
   a_setpoint_equal: assert property (vel_setpoint_r == vel_demand_r)
      else $error("setpoint differs from demand");
   a_vel_step_bound: assert property ($past(mode) == vtp_pkg::MODE_PROF_VEL
      && $past(op_enabled) && !$past(quick_stop) && $past(profile_type) == vtp_pkg::PROF_TRAP
      && $changed(vel_demand_r) |->
      mag($signed(vel_demand_r) - $signed($past(vel_demand_r))) <= $past(vstep))
      else $error("velocity step above rate");
   a_trq_cap_held: assert property (mode == vtp_pkg::MODE_PROF_TRQ
      |-> $signed(trq_demand_r) <= $signed(max_trq)) else $error("torque above max");
   a_trq_slope_bound: assert property ($past(mode) == vtp_pkg::MODE_PROF_TRQ
      && $past(closed_loop) && $past(op_enabled) && $changed(trq_demand_r) |->
      mag($signed(trq_demand_r) - $signed($past(trq_demand_r))) <= $past(tstep))
      else $error("torque step above slope");
   a_trq_open_loop: assert property ($past(mode) == vtp_pkg::MODE_PROF_TRQ
      && !$past(closed_loop) && $changed(trq_demand_r) |->
      mag($signed(trq_demand_r)) < mag($signed($past(trq_demand_r))))
      else $error("torque grew without closed loop");
   a_trq_limit_flag: assert property (mode == vtp_pkg::MODE_PROF_TRQ && closed_loop
      && op_enabled && $signed(target_trq) > $signed(max_trq) |-> ##[0:20] status_r[11])
      else $error("torque limit flag missing");
   a_cap_source: assert property ($rose(speed_cap_en_r) |->
      $past(mode) == vtp_pkg::MODE_PROF_TRQ && !$past(motor_submode[5]))
      else $error("speed cap enabled outside torque submode");
   a_weak_pair: assert property (field_weak_en_r == speed_cap_en_r)
      else $error("field weakening differs from speed cap");
   a_status_gap: assert property (PERIOD >= 4 && $changed(status_r)
      |=> $stable(status_r) [*3]) else $error("status changed between ticks");
   cover property ($rose(status_r[10]));
   cover property ($rose(status_r[11]));
   cover property ($rose(speed_cap_en_r));
endmodule
bind vtp_top vtp_monitor #(.PERIOD(PERIOD)) u_mon (.*);

/* File: dv/vtp_top_tb.sv */
module vtp_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int P = 8;
   logic clk = 1'b0, nrst = 1'b0, quick_stop = 1'b0, closed_loop = 1'b0, op_enabled;
   logic [7:0] mode, polarity = 8'h00, profile_type = 8'h00, motor_submode = 8'h00;
   logic [15:0] control, vel_window_ms = 16'h3, target_trq = 16'h0, max_trq = 16'h320;
   logic [15:0] trq_slope = 16'hc350, peak_trq = 16'h2bc, peak_dur = 16'h0;
   logic [15:0] actual_trq = 16'h0, trq_window = 16'ha, trq_window_ms = 16'h2;
   logic [31:0] target_vel = 32'h0, vel_min = 32'hffff_fc18, vel_max = 32'h3e8;
   logic [31:0] prof_acc = 32'ha, prof_dec = 32'h14, qs_dec = 32'h32, max_acc = 32'h3e8;
   logic [31:0] max_dec = 32'h3e8, jerk = 32'h2, actual_vel = 32'h0, vel_window = 32'h5;
   logic [31:0] speed_cap = 32'h0, vel_demand_r, vel_setpoint_r;
   logic [15:0] status_r, trq_demand_r;
   logic speed_cap_en_r, field_weak_en_r;
   int fail_count = 0;
   int checks_done = 0;
   vtp_top #(.PERIOD(P)) dut (.*);
   vtp_master m (.clk(clk), .mode(mode), .control(control), .op_enabled(op_enabled));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   initial forever #2.5 clk = ~clk;
   task automatic check(input string n, input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // Sample one step after the edge so the tick's updates have landed.
   task automatic ticks(input int n);
      repeat (n * P) @(posedge clk);
      #1;
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      #50000;
      fail_count++;
      results();
   end
   initial begin
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      target_vel <= 32'h64;
      actual_vel <= 32'h64;
      m.select(vtp_pkg::MODE_PROF_VEL);
      ticks(2);
      check("ramp", vel_demand_r inside {[32'h1:32'h14]}, 1'b1);
      ticks(30);
      check("vel", {vel_demand_r, vel_setpoint_r}, {32'h64, 32'h64});
      check("stat", status_r, 16'h0400);
      m.halt(1'b1);
      ticks(1);
      check("brake", status_r[10], 1'b0);
      @(posedge clk);
      actual_vel <= 32'h0;
      ticks(30);
      check("stop", {vel_demand_r, status_r}, {32'h0, 16'h0400});
      m.halt(1'b0);
      ticks(2);
      check("go", {vel_demand_r inside {[32'h1:32'h14]}, status_r[10]}, 2'b10);
      $display("test halt done");
      @(posedge clk);
      actual_vel <= 32'h64;
      ticks(30);
      @(posedge clk);
      actual_vel <= 32'h6e;
      ticks(2);
      check("out", status_r[10], 1'b0);
      @(posedge clk);
      actual_vel <= 32'h64;
      ticks(2);
      check("dwell", status_r[10], 1'b0);
      ticks(4);
      check("in", status_r[10], 1'b1);
      @(posedge clk);
      polarity <= 8'h40;
      actual_vel <= 32'hffff_ff9c;
      ticks(40);
      check("pol", {vel_demand_r, status_r}, {32'hffff_ff9c, 16'h0400});
      $display("test window done");
      @(posedge clk);
      polarity <= 8'h00;
      target_vel <= 32'h1388;
      prof_acc <= 32'h64;
      max_acc <= 32'h32;
      ticks(3);
      check("lim", status_r[11], 1'b1);
      ticks(40);
      check("max", {vel_demand_r, status_r[11]}, {32'h3e8, 1'b1});
      @(posedge clk);
      target_vel <= 32'h64;
      prof_dec <= 32'h64;
      max_acc <= 32'h3e8;
      ticks(20);
      check("free", {vel_demand_r, status_r[11]}, {32'h64, 1'b0});
      @(posedge clk);
      profile_type <= 8'h03;
      target_vel <= 32'hc8;
      ticks(30);
      check("jerk", vel_demand_r, 32'hc8);
      @(posedge clk);
      profile_type <= 8'h00;
      quick_stop <= 1'b1;
      max_dec <= 32'h28;
      ticks(20);
      check("qs", vel_demand_r, 32'h0);
      @(posedge clk);
      quick_stop <= 1'b0;
      target_vel <= 32'h1388;
      m.select(vtp_pkg::MODE_VEL);
      ticks(3);
      check("vlim", {vel_demand_r, status_r[11]}, {32'h12c, 1'b1});
      $display("test limits done");
      // Torque figures are thousandths of rated; peak below max sets the cap.
      @(posedge clk);
      quick_stop <= 1'b0;
      closed_loop <= 1'b1;
      target_trq <= 16'h04b0;
      actual_trq <= 16'h02bc;
      m.select(vtp_pkg::MODE_PROF_TRQ);
      ticks(30);
      check("peak", {trq_demand_r, status_r[11], speed_cap_en_r}, {16'h2bc, 2'b11});
      @(posedge clk);
      peak_trq <= 16'h07d0;
      peak_dur <= 16'h1;
      ticks(10);
      check("tmax", trq_demand_r, 16'h320);
      @(posedge clk);
      target_trq <= 16'h01f4;
      actual_trq <= 16'h01f4;
      ticks(20);
      check("treach", {trq_demand_r, status_r}, {16'h1f4, 16'h0400});
      m.halt(1'b1);
      @(posedge clk);
      actual_trq <= 16'h0;
      ticks(20);
      check("thalt", {trq_demand_r, status_r}, {16'h0, 16'h0400});
      m.halt(1'b0);
      ticks(2);
      check("tgo", {trq_demand_r, status_r[10]}, {16'h64, 1'b0});
      @(posedge clk);
      motor_submode <= 8'h20;
      ticks(2);
      check("sub", {speed_cap_en_r, field_weak_en_r}, 2'b00);
      @(posedge clk);
      closed_loop <= 1'b0;
      ticks(20);
      check("open", trq_demand_r, 16'h0);
      $display("test torque done");
      results();
   end
endmodule
